// ==== verilog/mscr_defs.vh ====
// Register map, field positions, reset values and timing counts of the startup configuration bank
`ifndef MSCR_DEFS_VH
`define MSCR_DEFS_VH
`define MSCR_ADDR_ADVANCE       8'h22
`define MSCR_ADDR_OPTION_ONE    8'h23
`define MSCR_ADDR_OPTION_TWO    8'h24
`define MSCR_RESET_ADVANCE      8'h00
`define MSCR_RESET_OPTION_ONE   8'h00
`define MSCR_RESET_OPTION_TWO   8'h00
`define MSCR_ADV_SEL_BIT        7
`define MSCR_ADV_SHIFT_HI       6
`define MSCR_ADV_SHIFT_LO       4
`define MSCR_ADV_MANT_HI        3
`define MSCR_ADV_MANT_LO        0
`define MSCR_STAT_THR_HI        7
`define MSCR_STAT_THR_LO        6
`define MSCR_ANGLE_HI           5
`define MSCR_ANGLE_LO           4
`define MSCR_ISD_EN_BIT         3
`define MSCR_REV_EN_BIT         2
`define MSCR_REV_THR_HI         1
`define MSCR_REV_THR_LO         0
`define MSCR_OL_CURR_HI         7
`define MSCR_OL_CURR_LO         6
`define MSCR_RAMP_HI            5
`define MSCR_RAMP_LO            3
`define MSCR_BRAKE_HI           2
`define MSCR_BRAKE_LO           0
`define MSCR_CLK_PERIOD_NS      20
`define MSCR_DELAY_STEP_NS      2500
`define MSCR_DELAY_STEP_CYC     (`MSCR_DELAY_STEP_NS / `MSCR_CLK_PERIOD_NS)
`define MSCR_STAT_BASE_MS       80
`define MSCR_CYC_PER_MS         (1000000 / `MSCR_CLK_PERIOD_NS)
`endif

// ==== verilog/mscr_regs.v ====
// Startup configuration register bank of the sensorless motor controller
//
// Behaviour
// - Advance select bit 7: 0 fixed advance time, 1 speed/supply dependent.
// - Advance delay equals 2.5 us times mantissa[3:0] shifted left by bits 6:4.
// - Stationary threshold codes mean 80, 160, 320, 640 ms without zero crossing.
// - Sense advance angle codes give 30, 60, 90, 120 degrees.
// - Option one bit 3 enables initial speed detection.
// - Option one bit 2 enables reverse drive.
// - Reverse or brake threshold codes mean 6.3, 13, 26, 51 Hz.
// - Open-loop current codes give 0.2, 0.4, 0.8, 1.6 A.
// - Open-loop ramp rate codes 000 to 111, 6 down to 0.023 Vcc/s.
// - Brake duration code 000 disables braking; others 2.7 s down to 0.04 s.
`timescale 1ns/1ns
`default_nettype none
`include "mscr_defs.vh"

module mscr_regs
#(
    parameter STAT_BASE_CYC = `MSCR_STAT_BASE_MS * `MSCR_CYC_PER_MS
)
(
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // Register access port, single-cycle write and registered read
    input  wire [7:0]  reg_addr,
    input  wire        reg_write,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // Advance timing to the control core
    output reg         advance_timing_select,
    output reg  [6:0]  advance_delay_value,
    output reg  [17:0] advance_delay_time,
    output reg  [24:0] advance_delay_cycles,
    // Initial speed detection and sensing
    output reg  [1:0]  stationary_threshold,
    output reg  [31:0] stationary_cycles,
    output reg  [1:0]  sense_advance_angle,
    output reg  [6:0]  sense_angle_degrees,
    output reg         initial_speed_detect_enable,
    // Reverse drive
    output reg         reverse_drive_enable,
    output reg  [1:0]  reverse_drive_threshold,
    // Open loop and braking
    output reg  [1:0]  open_loop_current,
    output reg  [2:0]  open_loop_ramp_rate,
    output reg  [2:0]  brake_duration,
    output reg         brake_enable
);

    // Address and reset value of every entry, packed lowest entry first
    localparam [23:0] ENTRY_ADDRS  = {`MSCR_ADDR_OPTION_TWO,
                                      `MSCR_ADDR_OPTION_ONE,
                                      `MSCR_ADDR_ADVANCE};
    localparam [23:0] ENTRY_RESETS = {`MSCR_RESET_OPTION_TWO,
                                      `MSCR_RESET_OPTION_ONE,
                                      `MSCR_RESET_ADVANCE};
    // Timing counts held at 32 bits so every product below is sized on purpose
    localparam [31:0] DELAY_STEP   = `MSCR_DELAY_STEP_CYC;
    localparam [31:0] STAT_BASE    = STAT_BASE_CYC;
    // One sense angle step, 30 degrees
    localparam [6:0]  ANGLE_STEP   = 7'h1E;

    // Storage, flattened lowest entry first, and per-entry address match
    wire [23:0] bank_flat;
    wire [2:0]  entry_hit;
    reg  [7:0]  next_rdata;
    // Named views of the storage
    wire [7:0]  advance_reg;
    wire [7:0]  option_one;
    wire [7:0]  option_two;
    // Advance delay fields and products
    wire [3:0]  mant;
    wire [2:0]  shift;
    wire [17:0] delay_units;
    wire [31:0] delay_cycles_full;
    // Option one fields and derived values
    wire [1:0]  thr;
    wire [1:0]  ang;
    wire        isd_bit;
    wire        rev_bit;
    wire [1:0]  rev_thr;
    wire [31:0] stat_cycles_full;
    wire [6:0]  angle_deg;
    // Option two fields
    wire [1:0]  curr_code;
    wire [2:0]  ramp_code;
    wire [2:0]  brake_code;
    wire        brake_on;

    // One storage entry per register; writes to unmapped addresses match no entry
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : entry
            reg [7:0] value;

            // Address match of this entry
            assign entry_hit[g] = (reg_addr == ENTRY_ADDRS[g*8 +: 8]);

            // Write storage; the read mux still sees the old value in the write cycle
            always @(posedge ref_clk)
            begin
                if (reset)
                    value <= ENTRY_RESETS[g*8 +: 8];
                else if (reg_write && entry_hit[g])
                    value <= reg_wdata;
            end

            // Hand the entry to the flat storage vector
            assign bank_flat[g*8 +: 8] = value;
        end
    endgenerate

    // Named views for the decode below
    assign advance_reg = bank_flat[7:0];
    assign option_one  = bank_flat[15:8];
    assign option_two  = bank_flat[23:16];

    // Read mux on the one-hot match; unmapped addresses read as zero
    always @*
    begin
        case (entry_hit)
            3'h1:    next_rdata = advance_reg;
            3'h2:    next_rdata = option_one;
            3'h4:    next_rdata = option_two;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read valid is a one-cycle pulse one edge after the strobe
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_read;
        end
    end

    // Read data holds the last answer until the next read
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
    end

    // Advance delay: mantissa shifted left; a shift of 7 needs 11 of the 18 bits
    assign mant              = advance_reg[`MSCR_ADV_MANT_HI:`MSCR_ADV_MANT_LO];
    assign shift             = advance_reg[`MSCR_ADV_SHIFT_HI:`MSCR_ADV_SHIFT_LO];
    assign delay_units       = {14'h0000, mant} << shift;
    // Product kept at 32 bits; its largest value needs 18, so the cut below loses nothing
    assign delay_cycles_full = {14'h0000, delay_units} * DELAY_STEP;

    // Option one fields
    assign thr              = option_one[`MSCR_STAT_THR_HI:`MSCR_STAT_THR_LO];
    assign ang              = option_one[`MSCR_ANGLE_HI:`MSCR_ANGLE_LO];
    assign isd_bit          = option_one[`MSCR_ISD_EN_BIT];
    assign rev_bit          = option_one[`MSCR_REV_EN_BIT];
    assign rev_thr          = option_one[`MSCR_REV_THR_HI:`MSCR_REV_THR_LO];
    // Base time doubles with each code step; 640 ms at 50 MHz fits easily in 32 bits
    assign stat_cycles_full = STAT_BASE << thr;
    // One step per code plus one step of offset, 120 degrees at most
    assign angle_deg        = ANGLE_STEP * {5'h00, ang} + ANGLE_STEP;

    // Option two fields; a zero brake code means no braking at all
    assign curr_code  = option_two[`MSCR_OL_CURR_HI:`MSCR_OL_CURR_LO];
    assign ramp_code  = option_two[`MSCR_RAMP_HI:`MSCR_RAMP_LO];
    assign brake_code = option_two[`MSCR_BRAKE_HI:`MSCR_BRAKE_LO];
    assign brake_on   = |brake_code;

    // Advance fields, registered so the core sees glitch-free values
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            advance_timing_select <= 1'b0;
            advance_delay_value   <= 7'h00;
        end
        else
        begin
            advance_timing_select <= advance_reg[`MSCR_ADV_SEL_BIT];
            advance_delay_value   <= advance_reg[`MSCR_ADV_SHIFT_HI:`MSCR_ADV_MANT_LO];
        end
    end

    // Advance delay in 2.5 us units and in clock cycles
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            advance_delay_time   <= 18'h00000;
            advance_delay_cycles <= 25'h0000000;
        end
        else
        begin
            advance_delay_time   <= delay_units;
            advance_delay_cycles <= delay_cycles_full[24:0];
        end
    end

    // Initial speed detection and sensing fields, one cycle behind storage
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            stationary_threshold        <= 2'h0;
            sense_advance_angle         <= 2'h0;
            initial_speed_detect_enable <= 1'b0;
        end
        else
        begin
            stationary_threshold        <= thr;
            sense_advance_angle         <= ang;
            initial_speed_detect_enable <= isd_bit;
        end
    end

    // Stationary time in cycles and advance angle in degrees
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            stationary_cycles   <= 32'h00000000;
            sense_angle_degrees <= 7'h00;
        end
        else
        begin
            stationary_cycles   <= stat_cycles_full;
            sense_angle_degrees <= angle_deg;
        end
    end

    // Reverse drive fields; the threshold applies to braking as well
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            reverse_drive_enable    <= 1'b0;
            reverse_drive_threshold <= 2'h0;
        end
        else
        begin
            reverse_drive_enable    <= rev_bit;
            reverse_drive_threshold <= rev_thr;
        end
    end

    // Open-loop current and its ramp rate
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            open_loop_current   <= 2'h0;
            open_loop_ramp_rate <= 3'h0;
        end
        else
        begin
            open_loop_current   <= curr_code;
            open_loop_ramp_rate <= ramp_code;
        end
    end

    // Brake duration code as written
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            brake_duration <= 3'h0;
        end
        else
        begin
            brake_duration <= brake_code;
        end
    end

    // Brake enable follows the code, so the core never needs to decode it
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            brake_enable <= 1'b0;
        end
        else
        begin
            brake_enable <= brake_on;
        end
    end

endmodule // mscr_regs
`default_nettype wire

// ==== test/mscr_regs_props.sv ====
// Checker of the startup configuration register bank ports
`timescale 1ns/1ns
`default_nettype none
module mscr_regs_props #(parameter STAT_BASE_CYC = 10)
(
    // Clock, reset and access port
    input wire logic ref_clk, reset, reg_write, reg_read, reg_rvalid,
    input wire logic [7:0] reg_addr, reg_wdata,
    // Field outputs
    input wire logic advance_timing_select, initial_speed_detect_enable, reverse_drive_enable,
    input wire logic brake_enable,
    input wire logic [6:0] advance_delay_value, sense_angle_degrees,
    input wire logic [17:0] advance_delay_time,
    input wire logic [24:0] advance_delay_cycles,
    input wire logic [31:0] stationary_cycles,
    input wire logic [1:0] stationary_threshold, sense_advance_angle, reverse_drive_threshold,
    input wire logic [1:0] open_loop_current,
    input wire logic [2:0] open_loop_ramp_rate, brake_duration
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Derived outputs reset to zero, not to their code-0 values, so the cycle leaving reset is skipped
    a_read_valid_pulse: assert property (!$past(reset) |-> reg_rvalid == $past(reg_read))
        else $error("read valid does not follow read strobe");
    a_adv_field_write: assert property (reg_write && reg_addr == 8'h22 |-> ##2
        {advance_timing_select, advance_delay_value} == $past(reg_wdata, 2))
        else $error("advance fields do not show written value");
    a_one_field_write: assert property (reg_write && reg_addr == 8'h23 |-> ##2
        {stationary_threshold, sense_advance_angle, initial_speed_detect_enable,
        reverse_drive_enable, reverse_drive_threshold} == $past(reg_wdata, 2))
        else $error("option one fields do not show written value");
    a_two_field_write: assert property (reg_write && reg_addr == 8'h24 |-> ##2
        {open_loop_current, open_loop_ramp_rate, brake_duration} == $past(reg_wdata, 2))
        else $error("option two fields do not show written value");
    a_delay_time_calc: assert property (!$past(reset) |-> advance_delay_time ==
        ({14'h0, advance_delay_value[3:0]} << advance_delay_value[6:4]))
        else $error("advance delay time wrong");
    a_delay_cyc_calc: assert property (advance_delay_cycles == advance_delay_time * 125)
        else $error("advance delay cycles wrong");
    a_stat_cyc_calc: assert property (!$past(reset) |->
        stationary_cycles == (STAT_BASE_CYC << stationary_threshold))
        else $error("stationary cycles wrong");
    a_angle_deg_calc: assert property (!$past(reset) |->
        sense_angle_degrees == 7'(30 * (sense_advance_angle + 1)))
        else $error("sense angle degrees wrong");
    a_brake_en_calc: assert property (!$past(reset) |-> brake_enable == (brake_duration != 3'h0))
        else $error("brake enable wrong");
endmodule // mscr_regs_props
bind mscr_regs mscr_regs_props #(.STAT_BASE_CYC(STAT_BASE_CYC)) i_mscr_regs_props (.ref_clk,
    .reset, .reg_write, .reg_read, .reg_rvalid, .reg_addr, .reg_wdata, .advance_timing_select,
    .initial_speed_detect_enable, .reverse_drive_enable, .brake_enable, .advance_delay_value,
    .sense_angle_degrees, .advance_delay_time, .advance_delay_cycles, .stationary_cycles,
    .stationary_threshold, .sense_advance_angle, .reverse_drive_threshold, .open_loop_current,
    .open_loop_ramp_rate, .brake_duration);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the startup configuration register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        ref_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, d, d1, d2;
    int          err_total = 0, comparisons = 0;
    wire [7:0]   reg_rdata;
    wire         reg_rvalid, advance_timing_select, initial_speed_detect_enable;
    wire         reverse_drive_enable, brake_enable;
    wire [6:0]   advance_delay_value, sense_angle_degrees;
    wire [17:0]  advance_delay_time;
    wire [24:0]  advance_delay_cycles;
    wire [31:0]  stationary_cycles;
    wire [1:0]   stationary_threshold, sense_advance_angle, reverse_drive_threshold;
    wire [1:0]   open_loop_current;
    wire [2:0]   open_loop_ramp_rate, brake_duration;
    // Small base count keeps the stationary figure readable
    mscr_regs #(.STAT_BASE_CYC(10)) i_mscr_regs (.ref_clk, .reset, .reg_addr, .reg_write,
        .reg_wdata, .reg_read, .reg_rdata, .reg_rvalid, .advance_timing_select,
        .advance_delay_value, .advance_delay_time, .advance_delay_cycles, .stationary_threshold,
        .stationary_cycles, .sense_advance_angle, .sense_angle_degrees,
        .initial_speed_detect_enable, .reverse_drive_enable, .reverse_drive_threshold,
        .open_loop_current, .open_loop_ramp_rate, .brake_duration, .brake_enable);
    // 50 MHz clock
    initial forever #10 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Strobes last one cycle each
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk({reg_rvalid, reg_rdata}, {1'b1, e});
    endtask
    // Main sequence: every code of every field written and seen, except mantissa codes 0 to 7
    initial
    begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            d = {i[0], i[2:0], ~i[3:0]};
            d1 = {i[1:0], ~i[1:0], i[0], i[1], i[1:0]};
            d2 = {i[1:0], i[2:0], ~i[2:0]};
            wr(8'h22, d);
            wr(8'h23, d1);
            wr(8'h24, d2);
            rd(8'h22, d);
            rd(8'h23, d1);
            rd(8'h24, d2);
            chk({advance_timing_select, advance_delay_value}, d);
            chk(advance_delay_time, {28'h0, d[3:0]} << d[6:4]);
            chk(advance_delay_cycles, ({28'h0, d[3:0]} << d[6:4]) * 125);
            chk(stationary_cycles, 10 << d1[7:6]);
            chk({stationary_threshold, sense_advance_angle}, d1[7:4]);
            chk(sense_angle_degrees, (d1[5:4] + 1) * 30);
            chk({initial_speed_detect_enable, reverse_drive_enable}, d1[3:2]);
            chk(reverse_drive_threshold, d1[1:0]);
            chk({open_loop_current, open_loop_ramp_rate}, d2[7:3]);
            chk({brake_enable, brake_duration}, {d2[2:0] != 3'h0, d2[2:0]});
        end
        wr(8'h25, 8'hFF);
        rd(8'h25, 8'h00);
        rd(8'h24, d2);
        rd(8'h22, d);
        rd(8'h23, d1);
        // Mid-run reset clears storage and every field code; stationary cycles and angle degrees come back as 10 and 30
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(8'h22, 8'h00);
        rd(8'h24, 8'h00);
        chk({advance_timing_select, advance_delay_value, advance_delay_time}, 32'h0);
        chk(advance_delay_cycles, 32'h0);
        chk({stationary_threshold, sense_advance_angle}, 32'h0);
        chk(stationary_cycles, 10);
        chk(sense_angle_degrees, 30);
        chk({initial_speed_detect_enable, reverse_drive_enable}, 32'h0);
        chk(reverse_drive_threshold, 32'h0);
        chk({open_loop_current, open_loop_ramp_rate}, 32'h0);
        chk({brake_duration, brake_enable}, 32'h0);
        give_verdict();
    end
    // Watchdog far beyond the roughly 120 cycles the tests need
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
